/* File: nrc_pkg.sv */
package nrc_pkg;

  // Register byte offsets on the Wishbone side.
  localparam logic [7:0] NRC_OFS_CMD     = 8'h00;
  localparam logic [7:0] NRC_OFS_ADDR    = 8'h04;
  localparam logic [7:0] NRC_OFS_WDATA   = 8'h08;
  localparam logic [7:0] NRC_OFS_RDATA   = 8'h0c;
  localparam logic [7:0] NRC_OFS_STATUS  = 8'h10;
  localparam logic [7:0] NRC_OFS_TIME_LO = 8'h14;
  localparam logic [7:0] NRC_OFS_TIME_HI = 8'h18;

  // Command bits in the command register.
  localparam int NRC_CMD_MRD = 0;
  localparam int NRC_CMD_MWR = 1;
  localparam int NRC_CMD_CRD = 2;
  localparam int NRC_CMD_CWR = 3;

  // Status bits.
  localparam int NRC_ST_BUSY  = 0;
  localparam int NRC_ST_PFAIL = 1;
  localparam int NRC_ST_ABORT = 2;

  // Device geometry and the clock access sequence.
  localparam int          NRC_AW       = 19;
  localparam int          NRC_KEY_BITS = 64;
  localparam logic [63:0] NRC_KEY      = 64'h5ca33ac5_5ca33ac5;
  localparam logic [5:0]  NRC_LAST_BIT = 6'h3f;

  // Pin timing: strobe low time covers the slowest cycle, recovery gap after it.
  localparam int         NRC_CLK_NS   = 20;
  localparam int         NRC_PULSE_NS = 150;
  localparam int         NRC_GAP_NS   = 20;
  localparam logic [3:0] NRC_PULSE_CYC = 4'((NRC_PULSE_NS + NRC_CLK_NS - 1) / NRC_CLK_NS);
  localparam logic [3:0] NRC_GAP_CYC   = 4'((NRC_GAP_NS + NRC_CLK_NS - 1) / NRC_CLK_NS);

  // Pin cycle sequencer states.
  typedef enum logic [1:0] {
    NRC_IDLE   = 2'b00,
    NRC_SETUP  = 2'b01,
    NRC_STROBE = 2'b10,
    NRC_RECOV  = 2'b11
  } nrc_state_t;

  // Kind of pin cycle under way.
  typedef enum logic [2:0] {
    NRC_JOB_MRD   = 3'b000,
    NRC_JOB_MWR   = 3'b001,
    NRC_JOB_OPEN  = 3'b010,
    NRC_JOB_KEY   = 3'b011,
    NRC_JOB_XFER  = 3'b100
  } nrc_job_t;

endpackage : nrc_pkg

/* File: nrc_host.sv */
// Summary of operation
// - Address steady in write; recovery gap after.
// - Output enable high while writing.
// - Clock opened by 64 key write cycles.
// - Open key sequence with one read.
// - Transfer covers all eight registers, LSB first.
// - Clock registers handled one bit at a time on data line 0.
// - Key is C5 3A A3 5C twice, LSB first.
`timescale 1ns/100ps
`default_nettype none

module nrc_host
  import nrc_pkg::*;
(
  input  wire logic               clk_i,       // System clock, 50 MHz.
  input  wire logic               rst_i,       // Synchronous reset, active high.
  input  wire logic               wb_cyc_i,    // Wishbone cycle.
  input  wire logic               wb_stb_i,    // Wishbone strobe.
  input  wire logic               wb_we_i,     // Wishbone write enable.
  input  wire logic [7:0]         wb_adr_i,    // Wishbone byte address.
  input  wire logic [3:0]         wb_sel_i,    // Wishbone byte selects.
  input  wire logic [31:0]        wb_dat_i,    // Wishbone write data.
  output logic      [31:0]        wb_dat_o,    // Wishbone read data.
  output logic                    wb_ack_o,    // Wishbone acknowledge.
  input  wire logic               pwr_fail_i,  // Device supply out of tolerance.
  output logic                    ce_n_o,      // Chip enable, active low.
  output logic                    oe_n_o,      // Output enable, active low.
  output logic                    we_n_o,      // Write strobe, active low.
  output logic      [NRC_AW-1:0]  addr_o,      // Address lines; top line doubles as abort.
  input  wire logic [7:0]         dq_i,        // Byte data lines, input side.
  output logic      [7:0]         dq_o,        // Byte data lines, output side.
  output logic                    dq_oe_o      // Byte data lines drive enable.
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merges a bus write into a register honouring the byte selects.
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i+:8] = new_v[8*i+:8];
      end
    end
    return res;
  endfunction : wb_merge

  // Tells whether a job drives the data lines with a write strobe.
  function automatic logic job_writes(input nrc_job_t job, input logic dir);
    return (job == NRC_JOB_MWR) || (job == NRC_JOB_KEY) || ((job == NRC_JOB_XFER) && dir);
  endfunction : job_writes

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  nrc_state_t        state_q, state_d;
  nrc_job_t          job_q, job_d;
  logic [5:0]        seq_q, seq_d;
  logic [3:0]        tmr_q, tmr_d;
  logic              dir_q;
  logic              abort_q;
  logic [NRC_AW-1:0] addr_reg_q;
  logic [7:0]        wdata_q, rdata_q;
  logic [63:0]       tbuf_q;
  logic              ack_q;
  logic [31:0]       dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave decode.

  // A request is latched when first seen and committed at the edge that samples ack.
  wire        acc      = wb_cyc_i && wb_stb_i && !ack_q;
  wire        commit   = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;
  wire        idle     = (state_q == NRC_IDLE);
  wire        hit_cmd  = commit && (wb_adr_i == NRC_OFS_CMD);
  wire        cfg_wr   = commit && idle;
  wire [3:0]  cmd      = wb_dat_i[3:0] & {4{wb_sel_i[0]}};
  wire        start    = hit_cmd && idle && !pwr_fail_i && (cmd != 4'h0);
  wire [31:0] status   = {29'h0, abort_q, pwr_fail_i, !idle};
  wire        strobe_end = (state_q == NRC_STROBE) && (tmr_q == 4'h0);
  wire        reading  = !job_writes(job_q, dir_q);
  wire [31:0] rd_mux   = (wb_adr_i == NRC_OFS_CMD)     ? 32'h0 :
                         (wb_adr_i == NRC_OFS_ADDR)    ? {13'h0, addr_reg_q} :
                         (wb_adr_i == NRC_OFS_WDATA)   ? {24'h0, wdata_q} :
                         (wb_adr_i == NRC_OFS_RDATA)   ? {24'h0, rdata_q} :
                         (wb_adr_i == NRC_OFS_STATUS)  ? status :
                         (wb_adr_i == NRC_OFS_TIME_LO) ? tbuf_q[31:0] :
                         (wb_adr_i == NRC_OFS_TIME_HI) ? tbuf_q[63:32] : 32'h0;

  // Byte-lane merges of the narrow configuration registers, cut back to width where they are stored.
  wire [31:0] adr_merged = wb_merge({13'h0, addr_reg_q}, wb_dat_i, wb_sel_i);
  wire [31:0] wd_merged  = wb_merge({24'h0, wdata_q}, wb_dat_i, wb_sel_i);

  // Bus answer one cycle after the request; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= acc;
      dat_q <= acc ? rd_mux : dat_q;
    end
  end

  // Configuration registers; writes are ignored while a pin sequence runs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg_q <= '0;
      wdata_q    <= 8'h0;
    end else if (cfg_wr) begin
      if (wb_adr_i == NRC_OFS_ADDR) addr_reg_q <= adr_merged[NRC_AW-1:0];
      if (wb_adr_i == NRC_OFS_WDATA) wdata_q <= wd_merged[7:0];
    end
  end

  // Clock image: byte lanes from software, single bits from the transfer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbuf_q <= 64'h0;
    end else if (cfg_wr && (wb_adr_i == NRC_OFS_TIME_LO)) begin
      tbuf_q[31:0] <= wb_merge(tbuf_q[31:0], wb_dat_i, wb_sel_i);
    end else if (cfg_wr && (wb_adr_i == NRC_OFS_TIME_HI)) begin
      tbuf_q[63:32] <= wb_merge(tbuf_q[63:32], wb_dat_i, wb_sel_i);
    end else if (strobe_end && (job_q == NRC_JOB_XFER) && reading) begin
      tbuf_q[seq_q] <= dq_i[0];
    end
  end

  // Memory read data and the abort flag; a new command clears the flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h0;
      abort_q <= 1'b0;
      dir_q   <= 1'b0;
    end else begin
      if (strobe_end && (job_q == NRC_JOB_MRD)) rdata_q <= dq_i;
      if ((state_q == NRC_RECOV) && pwr_fail_i) abort_q <= 1'b1;
      else if (start) abort_q <= 1'b0;
      if (start) dir_q <= cmd[NRC_CMD_CWR] && !cmd[NRC_CMD_CRD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin cycle sequencer.

  // Memory commands run one cycle; clock commands run open, 64 key, 64 transfer.
  always_comb begin
    state_d = state_q;
    job_d   = job_q;
    seq_d   = seq_q;
    tmr_d   = tmr_q;
    case (state_q)
      NRC_IDLE: begin
        if (start) begin
          state_d = NRC_SETUP;
          seq_d   = 6'h0;
          job_d   = cmd[NRC_CMD_MRD] ? NRC_JOB_MRD : cmd[NRC_CMD_MWR] ? NRC_JOB_MWR : NRC_JOB_OPEN;
        end
      end
      NRC_SETUP: begin
        state_d = NRC_STROBE;
        tmr_d   = NRC_PULSE_CYC - 4'h1;
      end
      NRC_STROBE: begin
        if (tmr_q == 4'h0) begin
          state_d = NRC_RECOV;
          tmr_d   = NRC_GAP_CYC - 4'h1;
        end else begin
          tmr_d = tmr_q - 4'h1;
        end
      end
      NRC_RECOV: begin
        if (tmr_q != 4'h0) begin
          tmr_d = tmr_q - 4'h1;
        end else if (pwr_fail_i) begin
          state_d = NRC_IDLE;
        end else begin
          state_d = NRC_SETUP;
          case (job_q)
            NRC_JOB_OPEN: job_d = NRC_JOB_KEY;
            NRC_JOB_KEY: begin
              seq_d = seq_q + 6'h1;
              if (seq_q == NRC_LAST_BIT) job_d = NRC_JOB_XFER;
            end
            NRC_JOB_XFER: begin
              seq_d = seq_q + 6'h1;
              if (seq_q == NRC_LAST_BIT) state_d = NRC_IDLE;
            end
            default: state_d = NRC_IDLE;
          endcase
        end
      end
      default: state_d = NRC_IDLE;
    endcase
  end

  // Next pin levels derived from the next sequencer state.
  wire       strobe_d = (state_d == NRC_STROBE);
  wire       wr_d     = job_writes(job_d, (state_q == NRC_IDLE) ? cmd[NRC_CMD_CWR] && !cmd[NRC_CMD_CRD] : dir_q);
  wire       clk_job  = (job_d == NRC_JOB_OPEN) || (job_d == NRC_JOB_KEY) || (job_d == NRC_JOB_XFER);
  wire [7:0] dq_d     = (job_d == NRC_JOB_MWR) ? wdata_q :
                        (job_d == NRC_JOB_KEY) ? {7'h0, NRC_KEY[seq_d]} : {7'h0, tbuf_q[seq_d]};

  // Sequencer state and pins, all from flip-flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= NRC_IDLE;
      job_q   <= NRC_JOB_MRD;
      seq_q   <= 6'h0;
      tmr_q   <= 4'h0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      dq_oe_o <= 1'b0;
      dq_o    <= 8'h0;
      addr_o  <= '0;
    end else begin
      state_q <= state_d;
      job_q   <= job_d;
      seq_q   <= seq_d;
      tmr_q   <= tmr_d;
      ce_n_o  <= !strobe_d;
      we_n_o  <= !(strobe_d && wr_d);
      oe_n_o  <= !(strobe_d && !wr_d);
      dq_oe_o <= strobe_d && wr_d;
      dq_o    <= dq_d;
      // Clock sequences hold the top line high so the abort input never fires.
      addr_o  <= clk_job ? {1'b1, addr_reg_q[NRC_AW-2:0]} : addr_reg_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_strobe_pulse;
    (!ce_n_o)[*8] ##1 ce_n_o;
  endsequence

  a_strobe_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(ce_n_o) |-> s_strobe_pulse) else $error("Strobe width wrong.");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (!we_n_o && $past(!we_n_o)) |-> $stable(addr_o)) else $error("Address moved in write.");
  a_write_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(we_n_o) |-> we_n_o ##1 ce_n_o) else $error("No write recovery gap.");
  a_oe_in_write: assert property (@(posedge clk_i) disable iff (rst_i)
    !we_n_o |-> (oe_n_o && dq_oe_o && !ce_n_o)) else $error("Output enable low in write.");
  a_drive_only_write: assert property (@(posedge clk_i) disable iff (rst_i)
    dq_oe_o |-> !we_n_o) else $error("Data driven outside write.");
  a_key_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (!we_n_o && job_q == NRC_JOB_KEY) |-> dq_o[0] == NRC_KEY[seq_q]) else $error("Wrong key bit.");
  a_open_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ce_n_o && job_q == NRC_JOB_OPEN) |-> (we_n_o && !oe_n_o)) else $error("Opening cycle not a read.");
  a_key_to_xfer: assert property (@(posedge clk_i) disable iff (rst_i)
    (job_q == NRC_JOB_XFER && $past(job_q) == NRC_JOB_KEY) |-> $past(seq_q) == NRC_LAST_BIT)
    else $error("Key sequence not 64 long.");
  a_xfer_all_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle && $past(state_q) == NRC_RECOV && $past(job_q) == NRC_JOB_XFER && !$past(pwr_fail_i))
    |-> $past(seq_q) == NRC_LAST_BIT) else $error("Transfer ended early.");
  a_no_start_pfail: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle && pwr_fail_i) |=> ce_n_o ##1 ce_n_o) else $error("Access during supply fail.");

endmodule : nrc_host

`default_nettype wire

/* File: nrc_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nrc_dev_model
  import nrc_pkg::*;
#(
  parameter logic [63:0] TIME_INIT = 64'h0
)(
  input  wire logic              clk_i,      // Sampling clock.
  input  wire logic              pwr_fail_i, // Supply out of tolerance.
  input  wire logic              ce_n_i,     // Chip enable, active low.
  input  wire logic              oe_n_i,     // Output enable, active low.
  input  wire logic              we_n_i,     // Write strobe, active low.
  input  wire logic [NRC_AW-1:0] addr_i,     // Address lines.
  input  wire logic [7:0]        dq_i,       // Host drive on the data lines.
  input  wire logic              dq_oe_i,    // Host drive enable.
  output logic      [7:0]        dq_o        // Resolved data lines.
);
  localparam logic [63:0] KEY_SEQ = {2{8'h5c, 8'ha3, 8'h3a, 8'hc5}};
  logic [7:0]  mem [0:524287];
  logic [63:0] time_q = TIME_INIT; // Eight BCD bytes, register 0 lowest.
  logic [5:0]  ptr_q = '0;
  logic [5:0]  cnt_q = '0;
  logic        armed_q = 1'b0;
  logic        xfer_q = 1'b0;
  logic        wr_q = 1'b0;
  logic        ce_q = 1'b1;
  logic [7:0]  wd_q = '0;
  logic [7:0]  last_q = '0;
  // Outputs drive only in a read; a released bus shows the inverse level so stale data never passes.
  wire       rd_drv = !ce_n_i && !oe_n_i && we_n_i && !pwr_fail_i;
  wire [7:0] rd_val = xfer_q ? {7'h0, time_q[cnt_q]} : mem[addr_i];
  assign dq_o = rd_drv ? rd_val : (dq_oe_i ? dq_i : ~last_q);
  // A low top address line cancels a transfer unless day register bit 4 masks it; clock bits are kept.
  wire       abort_pin = !addr_i[NRC_AW-1] && !time_q[36];
  // A cycle is judged when chip enable rises; cycles under a supply fault are dropped.
  always @(posedge clk_i) begin
    last_q <= dq_o;
    ce_q <= ce_n_i;
    if (!ce_n_i && !we_n_i) begin
      wr_q <= 1'b1;
      wd_q <= dq_i;
    end
    if (ce_n_i && !ce_q) begin
      wr_q <= 1'b0;
      if (pwr_fail_i) begin
      end else if (xfer_q && abort_pin) begin
        xfer_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (xfer_q) begin
        if (wr_q) time_q[cnt_q] <= wd_q[0];
        cnt_q <= cnt_q + 6'h1;
        if (cnt_q == 6'h3f) begin
          xfer_q <= 1'b0;
          armed_q <= 1'b0;
        end
      end else if (!wr_q) begin
        ptr_q <= '0;
        armed_q <= 1'b1;
      end else begin
        mem[addr_i] <= wd_q;
        if (armed_q && wd_q[0] == KEY_SEQ[ptr_q]) begin
          ptr_q <= ptr_q + 6'h1;
          xfer_q <= (ptr_q == 6'h3f);
          cnt_q <= '0;
        end else begin
          armed_q <= 1'b0;
        end
      end
    end
  end
endmodule : nrc_dev_model
`default_nettype wire

/* File: nrc_host_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module nrc_host_tb
  import nrc_pkg::*;
;
  localparam logic [63:0] TIME_INIT = 64'h2404150312304500;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pwr = 1'b0, ack;
  logic        ce_n, oe_n, we_n, dq_oe, pw_q = 1'b0;
  logic [7:0]  adr = '0, dq_h, dq_d, md [8];
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0, rdat, r;
  logic [18:0] addr, pa_q, ma [8];
  logic [63:0] t, tv;
  int          miscompares = 0, samples_checked = 0;

  nrc_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pwr_fail_i(pwr), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr),
    .dq_i(dq_d), .dq_o(dq_h), .dq_oe_o(dq_oe));
  nrc_dev_model #(.TIME_INIT(TIME_INIT)) u_dev (.clk_i(clk_i), .pwr_fail_i(pwr), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(dq_h), .dq_oe_i(dq_oe), .dq_o(dq_d));

  // Clock at 50 MHz.
  always #10 clk_i = ~clk_i;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; read data lands in r.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic idle();
    do begin
      bus(1'b0, NRC_OFS_STATUS, '0);
    end while (r[NRC_ST_BUSY] !== 1'b0);
  endtask : idle

  task automatic cmd(input int b, input logic [18:0] a);
    bus(1'b1, NRC_OFS_ADDR, 32'(a));
    bus(1'b1, NRC_OFS_CMD, 32'h1 << b);
    idle();
  endtask : cmd

  task automatic rd_time();
    bus(1'b0, NRC_OFS_TIME_LO, '0);
    t[31:0] = r;
    bus(1'b0, NRC_OFS_TIME_HI, '0);
    t[63:32] = r;
  endtask : rd_time

  // Random time value made of BCD digit pairs.
  function automatic logic [63:0] bcd_word();
    logic [63:0] v;
    for (int i = 0; i < 8; i++) v[i*8 +: 8] = {4'($urandom_range(5, 0)), 4'($urandom_range(9, 0))};
    return v;
  endfunction : bcd_word

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////////////
  // Pin watcher: strobes and address during every write pulse.
  always @(posedge clk_i) begin
    if (!rst_i && !ce_n && !we_n) begin
      chk(oe_n, 1'b1);
      if (pw_q) chk(addr, pa_q);
    end
    pw_q <= !ce_n && !we_n;
    pa_q <= addr;
  end

  // Main sequence.
  initial begin
    void'($urandom(17));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({ce_n, oe_n, we_n, dq_oe}, 64'he);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      ma[i] = {3'(i), (i == 0) ? 16'h0 : (i == 7) ? 16'hffff : 16'($urandom)};
      md[i] = 8'($urandom);
      bus(1'b1, NRC_OFS_WDATA, 32'(md[i]));
      cmd(NRC_CMD_MWR, ma[i]);
    end
    for (int i = 0; i < 8; i++) begin
      cmd(NRC_CMD_MRD, ma[i]);
      bus(1'b0, NRC_OFS_RDATA, '0);
      chk(r[7:0], md[i]);
    end
    $display("test memory done");
    cmd(NRC_CMD_CRD, 19'h01234);
    rd_time();
    chk(t, TIME_INIT);
    tv = bcd_word();
    bus(1'b1, NRC_OFS_TIME_LO, tv[31:0]);
    bus(1'b1, NRC_OFS_TIME_HI, tv[63:32]);
    cmd(NRC_CMD_CWR, 19'h01234);
    chk(u_dev.time_q, tv);
    bus(1'b1, NRC_OFS_TIME_LO, '0);
    bus(1'b1, NRC_OFS_TIME_HI, '0);
    cmd(NRC_CMD_CRD, 19'h01234);
    rd_time();
    chk(t, tv);
    // Key writes land where the clock sequence puts them: top address line held high.
    cmd(NRC_CMD_MRD, 19'h41234);
    bus(1'b0, NRC_OFS_RDATA, '0);
    chk(r[7:0], {7'h0, NRC_KEY[63]});
    $display("test clock done");
    pwr <= 1'b1;
    bus(1'b0, NRC_OFS_STATUS, '0);
    chk(r[NRC_ST_PFAIL], 1'b1);
    bus(1'b1, NRC_OFS_CMD, 32'h1 << NRC_CMD_MWR);
    repeat (4) @(posedge clk_i);
    chk(ce_n, 1'b1);
    pwr <= 1'b0;
    bus(1'b1, NRC_OFS_CMD, 32'h1 << NRC_CMD_CRD);
    repeat (300) @(posedge clk_i);
    pwr <= 1'b1;
    idle();
    chk(r[NRC_ST_ABORT], 1'b1);
    pwr <= 1'b0;
    cmd(NRC_CMD_CRD, 19'h01234);
    rd_time();
    chk(t, tv);
    bus(1'b0, 8'h40, '0);
    chk(r, 32'h0); // Unmapped offset reads zero.
    $display("test power fail done");
    wrap_up();
  end

  // Watchdog well beyond the expected run.
  initial begin
    #(20 * 60000);
    miscompares++;
    wrap_up();
  end
endmodule : nrc_host_tb
`default_nettype wire
